// ==== sdta_map.svh ====
/*
  Constants for the secure debug trace access block: register offsets,
  field positions, reset values, command opcodes and timing counts.
  Assumes it is included by name before any file that uses the macros.
*/
`ifndef SDTA_MAP_SVH
`define SDTA_MAP_SVH

// Register byte offsets on the AXI4-Lite bus
`define SDTA_OFS_CTRL     8'h00
`define SDTA_OFS_STATUS   8'h04
`define SDTA_OFS_FLASH_SECURITY_REG     8'h08
// Control register fields
`define SDTA_CTRL_ACKEN   0
`define SDTA_CTRL_TMOCLR  1
`define SDTA_CTRL_RST     1'h0
// Status fields, shared by bus status and the debug status byte
`define SDTA_ST_LOADED    0
`define SDTA_ST_SECURED   1
`define SDTA_ST_ACTIVE    2
`define SDTA_ST_SPECIAL   3
`define SDTA_ST_TMO       4
`define SDTA_ST_ACKEN     5
`define SDTA_ST_BUSY      6
// Security field and its one open pattern
`define SDTA_SEC_LSB      0
`define SDTA_SEC_OPEN     2'h2
`define SDTA_SEC_ADVISED  2'h1
`define SDTA_FLASH_SECURITY_REG_RST     8'h00
// Command opcodes seen on the debug port
`define SDTA_OP_READ_TB   8'h07
`define SDTA_OP_CSR_RD    8'h2D
`define SDTA_OP_CSR_WR    8'h0D
`define SDTA_OP_ERASE     8'h95
`define SDTA_OP_MEM_RD    8'h30
`define SDTA_OP_MEM_RD_WS 8'h31
// Timing counts in clock cycles
`define SDTA_TMO_CYC      8'hFF
`define SDTA_DLY_CYC      5'h10
// AXI responses
`define SDTA_RESP_OKAY    2'h0
`define SDTA_RESP_SLVERR  2'h2

`endif

// ==== sdta_pkg.sv ====
/*
  Types for the secure debug trace access block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sdta_pkg;
  // Controller sequence
  typedef enum logic [2:0] {ST_IDLE, ST_ARG, ST_FETCH, ST_ACK, ST_SEND} sdta_state_e;
  // Kind of command in progress
  typedef enum logic [1:0] {OP_NONE, OP_TB, OP_MEM, OP_MEM_WS} sdta_op_e;
  // One response byte toward the host
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sdta_rsp_s;
endpackage

// ==== sdta_sec.sv ====
/*
  Security state: holds the flash security register, loaded from the
  nonvolatile security byte after every reset, and the unsecure routes.
  Assumes the nonvolatile byte is stable when reset is released.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sdta_map.svh"

module sdta_sec (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Nonvolatile byte and unsecure events
  input  wire logic [7:0] nv_byte_i,
  input  wire logic       backdoor_i,
  input  wire logic       prog_we_i,
  input  wire logic [7:0] prog_byte_i,
  input  wire logic       erase_done_i,
  // State
  output logic      [7:0] flash_security_reg_o,
  output logic            loaded_o,
  output logic            secured_o
);
  logic [7:0] flash_security_reg_r, flash_security_reg_nxt;
  logic       pend_r, loaded_r, loaded_nxt;

  // Copy taken one edge after release, never under reset itself
  always_comb begin
    flash_security_reg_nxt   = flash_security_reg_r;
    loaded_nxt = loaded_r | pend_r;
    if (pend_r) begin
      flash_security_reg_nxt = nv_byte_i;
    end else if (prog_we_i) begin
      flash_security_reg_nxt = prog_byte_i;
    end else if (backdoor_i || erase_done_i) begin
      flash_security_reg_nxt[`SDTA_SEC_LSB+:2] = `SDTA_SEC_OPEN;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_security_reg_r <= `SDTA_FLASH_SECURITY_REG_RST;
      pend_r               <= 1'b1;
      loaded_r             <= 1'b0;
    end else begin
      flash_security_reg_r <= flash_security_reg_nxt;
      pend_r               <= 1'b0;
      loaded_r             <= loaded_nxt;
    end
  end

  assign flash_security_reg_o    = flash_security_reg_r;
  assign loaded_o  = loaded_r;
  // Only one pattern opens the device
  assign secured_o = flash_security_reg_r[`SDTA_SEC_LSB+:2] != `SDTA_SEC_OPEN;

  a_load_after_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    pend_r && !rst_i |=> flash_security_reg_r == $past(nv_byte_i))
    else $error("security byte not copied after reset");
endmodule // sdta_sec

`default_nettype wire

// ==== sdta_ser.sv ====
/*
  Response serializer: sends up to four bytes of a word, most significant
  byte first, one byte per clock. Assumes load only while idle.
*/
`timescale 1ns/10ps
`default_nettype none

module sdta_ser (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Load side
  input  wire logic              load_i,
  input  wire logic [31:0]       word_i,
  input  wire logic [2:0]        nbytes_i,
  output logic                   idle_o,
  // Byte stream
  output sdta_pkg::sdta_rsp_s    rsp_o
);
  logic [31:0]         word_r, word_nxt;
  logic [2:0]          cnt_r, cnt_nxt;
  sdta_pkg::sdta_rsp_s rsp_r, rsp_nxt;

  // Shift out from the top byte
  always_comb begin
    word_nxt = word_r;
    cnt_nxt  = cnt_r;
    rsp_nxt  = '0;
    if (load_i) begin
      word_nxt = word_i;
      cnt_nxt  = nbytes_i;
    end else if (cnt_r != 3'h0) begin
      rsp_nxt.valid = 1'b1;
      rsp_nxt.data  = word_r[31:24];
      word_nxt      = {word_r[23:0], 8'h00};
      cnt_nxt       = cnt_r - 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_r <= 32'h0000_0000;
      cnt_r  <= 3'h0;
      rsp_r  <= '0;
    end else begin
      word_r <= word_nxt;
      cnt_r  <= cnt_nxt;
      rsp_r  <= rsp_nxt;
    end
  end

  assign idle_o = cnt_r == 3'h0; // Count only, so no loop back through the loader
  assign rsp_o  = rsp_r;
endmodule // sdta_ser

`default_nettype wire

// ==== sdta_top.sv ====
/*
  Secure debug trace access: gates debug port commands by the security
  state and serves trace buffer, memory read, status and erase commands.
  Assumes a host that sends command bytes one per valid cycle and waits
  for the answer, and an AXI4-Lite master for the control registers.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sdta_map.svh"

module sdta_top #(
  parameter bit TRACE_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  // AXI4-Lite slave
  input  wire logic        AXI_AWVALID_I,
  input  wire logic [7:0]  AXI_AWADDR_I,
  output logic             AXI_AWREADY_O,
  input  wire logic        AXI_WVALID_I,
  input  wire logic [31:0] AXI_WDATA_I,
  input  wire logic [3:0]  AXI_WSTRB_I,
  output logic             AXI_WREADY_O,
  output logic             AXI_BVALID_O,
  output logic [1:0]       AXI_BRESP_O,
  input  wire logic        AXI_BREADY_I,
  input  wire logic        AXI_ARVALID_I,
  input  wire logic [7:0]  AXI_ARADDR_I,
  output logic             AXI_ARREADY_O,
  output logic             AXI_RVALID_O,
  output logic [31:0]      AXI_RDATA_O,
  output logic [1:0]       AXI_RRESP_O,
  input  wire logic        AXI_RREADY_I,
  // Debug host command and response
  input  wire logic        HOST_VALID_I,
  input  wire logic [7:0]  HOST_BYTE_I,
  output logic             HOST_READY_O,
  output logic             RSP_VALID_O,
  output logic [7:0]       RSP_BYTE_O,
  output logic             RSP_ACK_O,
  // Security sources and results
  input  wire logic        SPECIAL_MODE_I,
  input  wire logic [7:0]  NV_SEC_BYTE_I,
  input  wire logic        BACKDOOR_OK_I,
  input  wire logic        SEC_PROG_WE_I,
  input  wire logic [7:0]  SEC_PROG_BYTE_I,
  input  wire logic        ERASE_DONE_I,
  output logic             MASS_ERASE_O,
  output logic             FLASH_RESTRICT_O,
  output logic             SECURED_O,
  output logic             DEBUG_ACTIVE_O,
  // Trace buffer port
  output logic             TB_REQ_O,
  output logic             TB_HI_O,
  input  wire logic        TB_RDY_I,
  input  wire logic [31:0] TB_DATA_I,
  // Memory read port
  output logic             MEM_REQ_O,
  output logic [23:0]      MEM_ADDR_O,
  input  wire logic        MEM_ACK_I,
  input  wire logic [7:0]  MEM_RDATA_I
);
  logic [7:0]            flash_security_reg;
  logic                  loaded, secured, ser_idle, ser_load;
  logic [31:0]           ser_word;
  logic [2:0]            ser_n;
  sdta_pkg::sdta_rsp_s   ser_rsp;
  sdta_pkg::sdta_state_e state_r, state_nxt;
  sdta_pkg::sdta_op_e    op_r, op_nxt;
  logic [23:0]           addr_r, addr_nxt;
  logic [1:0]            argc_r, argc_nxt;
  logic                  csrw_r, csrw_nxt, hi_r, hi_nxt, req_r, req_nxt;
  logic [7:0]            tmo_r, tmo_nxt;
  logic [31:0]           data_r, data_nxt;
  logic                  ack_en_r, ack_en_nxt, tmo_flag_r, tmo_flag_nxt;
  logic                  active_r, active_nxt, special_r, special_nxt;
  logic                  seen_r, erase_r, erase_nxt, ack_r, ack_nxt;
  logic                  sec_r, enabled, allowed, tmo_set, set_ack, clr_tmo;
  logic [7:0]            status;

  sdta_sec u_sec (
    .clk_i        (CLK_I),
    .rst_i        (SYS_RST_I),
    .nv_byte_i    (NV_SEC_BYTE_I),
    .backdoor_i   (BACKDOOR_OK_I),
    .prog_we_i    (SEC_PROG_WE_I),
    .prog_byte_i  (SEC_PROG_BYTE_I),
    .erase_done_i (ERASE_DONE_I),
    .flash_security_reg_o       (flash_security_reg),
    .loaded_o     (loaded),
    .secured_o    (secured)
  );

  sdta_ser u_ser (
    .clk_i    (CLK_I),
    .rst_i    (SYS_RST_I),
    .load_i   (ser_load),
    .word_i   (ser_word),
    .nbytes_i (ser_n),
    .idle_o   (ser_idle),
    .rsp_o    (ser_rsp)
  );

  // Status byte, also the body of the status register
  always_comb begin
    status = 8'h00;
    status[`SDTA_ST_LOADED]  = loaded;
    status[`SDTA_ST_SECURED] = secured;
    status[`SDTA_ST_ACTIVE]  = active_r;
    status[`SDTA_ST_SPECIAL] = special_r;
    status[`SDTA_ST_TMO]     = tmo_flag_r;
    status[`SDTA_ST_ACKEN]   = ack_en_r;
    status[`SDTA_ST_BUSY]    = state_r != sdta_pkg::ST_IDLE;
  end

  // Secured normal mode shuts the port; secured special mode filters it
  assign enabled = loaded && !(secured && !special_r);
  assign allowed = !secured || HOST_BYTE_I == `SDTA_OP_ERASE
                 || HOST_BYTE_I == `SDTA_OP_CSR_RD || HOST_BYTE_I == `SDTA_OP_CSR_WR;

  // Command sequencer
  always_comb begin
    state_nxt   = state_r;
    op_nxt      = op_r;
    addr_nxt    = addr_r;
    argc_nxt    = argc_r;
    csrw_nxt    = csrw_r;
    hi_nxt      = hi_r;
    req_nxt     = req_r;
    tmo_nxt     = tmo_r;
    data_nxt    = data_r;
    erase_nxt   = 1'b0;
    ack_nxt     = 1'b0;
    ser_load    = 1'b0;
    ser_word    = 32'h0000_0000;
    ser_n       = 3'h0;
    tmo_set     = 1'b0;
    set_ack     = 1'b0;
    active_nxt  = active_r;
    special_nxt = special_r;
    if (!seen_r && loaded) begin
      special_nxt = SPECIAL_MODE_I;
      active_nxt  = SPECIAL_MODE_I;
    end
    unique case (state_r)
      sdta_pkg::ST_IDLE: begin
        if (HOST_VALID_I && enabled && allowed) begin
          unique case (HOST_BYTE_I)
            `SDTA_OP_READ_TB: begin
              op_nxt    = sdta_pkg::OP_TB;
              hi_nxt    = 1'b0;
              req_nxt   = TRACE_PRESENT;
              tmo_nxt   = 8'h00;
              data_nxt  = 32'h0000_0000;
              state_nxt = sdta_pkg::ST_FETCH;
            end
            `SDTA_OP_MEM_RD, `SDTA_OP_MEM_RD_WS: begin
              op_nxt    = (HOST_BYTE_I == `SDTA_OP_MEM_RD) ? sdta_pkg::OP_MEM
                                                           : sdta_pkg::OP_MEM_WS;
              csrw_nxt  = 1'b0;
              argc_nxt  = 2'h0;
              state_nxt = sdta_pkg::ST_ARG;
            end
            `SDTA_OP_CSR_WR: begin
              csrw_nxt  = 1'b1;
              state_nxt = sdta_pkg::ST_ARG;
            end
            `SDTA_OP_CSR_RD: begin
              ser_load  = 1'b1;
              ser_word  = {status, 24'h00_0000};
              ser_n     = 3'h1;
              op_nxt    = sdta_pkg::OP_NONE;
              state_nxt = sdta_pkg::ST_SEND;
            end
            `SDTA_OP_ERASE: erase_nxt = 1'b1;
            default: ;
          endcase
        end
      end
      sdta_pkg::ST_ARG: begin
        if (HOST_VALID_I && csrw_r) begin
          set_ack   = 1'b1;
          state_nxt = sdta_pkg::ST_IDLE;
        end else if (HOST_VALID_I) begin
          addr_nxt = {addr_r[15:0], HOST_BYTE_I};
          argc_nxt = argc_r + 2'h1;
          if (argc_r == 2'h2) begin
            req_nxt   = !secured;
            tmo_nxt   = 8'h00;
            state_nxt = secured ? sdta_pkg::ST_IDLE : sdta_pkg::ST_FETCH;
          end
        end
      end
      sdta_pkg::ST_FETCH: begin
        tmo_nxt = tmo_r + 8'h01;
        if (!req_r || (op_r == sdta_pkg::OP_TB ? TB_RDY_I : MEM_ACK_I)) begin
          req_nxt   = 1'b0;
          if (req_r) begin
            data_nxt = (op_r == sdta_pkg::OP_TB) ? TB_DATA_I : {24'h00_0000, MEM_RDATA_I};
          end
          state_nxt = sdta_pkg::ST_ACK;
        end else if (tmo_r == `SDTA_TMO_CYC) begin
          req_nxt   = 1'b0;
          tmo_set   = 1'b1;
          state_nxt = sdta_pkg::ST_IDLE;
        end
      end
      sdta_pkg::ST_ACK: begin
        ack_nxt   = ack_en_r && op_r != sdta_pkg::OP_MEM_WS;
        ser_load  = 1'b1;
        state_nxt = sdta_pkg::ST_SEND;
        unique case (op_r)
          sdta_pkg::OP_TB: begin
            ser_word = data_r;
            ser_n    = 3'h4;
          end
          sdta_pkg::OP_MEM_WS: begin
            ser_word = {status, data_r[7:0], 16'h0000};
            ser_n    = 3'h2;
          end
          default: begin
            ser_word = {data_r[7:0], 24'h00_0000};
            ser_n    = 3'h1;
          end
        endcase
      end
      sdta_pkg::ST_SEND: begin
        if (ser_idle) begin
          state_nxt = sdta_pkg::ST_IDLE;
          if (op_r == sdta_pkg::OP_TB && !hi_r) begin
            hi_nxt    = 1'b1;
            req_nxt   = TRACE_PRESENT;
            tmo_nxt   = 8'h00;
            data_nxt  = 32'h0000_0000;
            state_nxt = sdta_pkg::ST_FETCH;
          end
        end
      end
      default: state_nxt = sdta_pkg::ST_IDLE;
    endcase
  end

  // AXI4-Lite slave state
  logic        awh_r, awh_nxt, wh_r, wh_nxt, bv_r, bv_nxt, arr_r, arr_nxt, rv_r, rv_nxt;
  logic [7:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic        bus_wr;

  always_comb begin
    awh_nxt = awh_r;
    awa_nxt = awa_r;
    wh_nxt  = wh_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    bv_nxt  = bv_r && !AXI_BREADY_I;
    br_nxt  = br_r;
    arr_nxt = arr_r;
    rv_nxt  = rv_r;
    rd_nxt  = rd_r;
    rr_nxt  = rr_r;
    bus_wr  = 1'b0;
    if (AXI_AWVALID_I && !awh_r) begin
      awh_nxt = 1'b1;
      awa_nxt = AXI_AWADDR_I;
    end
    if (AXI_WVALID_I && !wh_r) begin
      wh_nxt = 1'b1;
      wd_nxt = AXI_WDATA_I;
      ws_nxt = AXI_WSTRB_I;
    end
    if (awh_r && wh_r && !bv_r) begin
      bus_wr  = awa_r == `SDTA_OFS_CTRL;
      br_nxt  = (awa_r == `SDTA_OFS_CTRL) ? `SDTA_RESP_OKAY : `SDTA_RESP_SLVERR;
      bv_nxt  = 1'b1;
      awh_nxt = 1'b0;
      wh_nxt  = 1'b0;
    end
    if (rv_r && AXI_RREADY_I) begin
      rv_nxt  = 1'b0;
      arr_nxt = 1'b1;
    end else if (AXI_ARVALID_I && arr_r) begin
      arr_nxt = 1'b0;
      rv_nxt  = 1'b1;
      rr_nxt  = `SDTA_RESP_OKAY;
      unique case (AXI_ARADDR_I)
        `SDTA_OFS_CTRL:   rd_nxt = {31'h0000_0000, ack_en_r};
        `SDTA_OFS_STATUS: rd_nxt = {24'h00_0000, status};
        `SDTA_OFS_FLASH_SECURITY_REG:   rd_nxt = {24'h00_0000, flash_security_reg};
        default: begin
          rd_nxt = 32'h0000_0000;
          rr_nxt = `SDTA_RESP_SLVERR;
        end
      endcase
    end
  end

  // Acknowledge enable written from both sides; a timeout beats its clear
  assign clr_tmo = bus_wr && ws_r[0] && wd_r[`SDTA_CTRL_TMOCLR];
  always_comb begin
    ack_en_nxt = ack_en_r;
    if (set_ack) begin
      ack_en_nxt = HOST_BYTE_I[`SDTA_CTRL_ACKEN];
    end else if (bus_wr && ws_r[0]) begin
      ack_en_nxt = wd_r[`SDTA_CTRL_ACKEN];
    end
    tmo_flag_nxt = tmo_set || (tmo_flag_r && !clr_tmo);
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_r <= sdta_pkg::ST_IDLE;
      op_r    <= sdta_pkg::OP_NONE;
      {addr_r, argc_r, csrw_r, hi_r, req_r, tmo_r, data_r} <= '0;
      {erase_r, ack_r, active_r, special_r, seen_r, sec_r} <= {5'h00, 1'b1};
      ack_en_r   <= `SDTA_CTRL_RST;
      tmo_flag_r <= 1'b0;
      {awh_r, awa_r, wh_r, wd_r, ws_r, bv_r, br_r} <= '0;
      {rv_r, rd_r, rr_r} <= '0;
      arr_r <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      op_r       <= op_nxt;
      addr_r     <= addr_nxt;
      argc_r     <= argc_nxt;
      csrw_r     <= csrw_nxt;
      hi_r       <= hi_nxt;
      req_r      <= req_nxt;
      tmo_r      <= tmo_nxt;
      data_r     <= data_nxt;
      erase_r    <= erase_nxt;
      ack_r      <= ack_nxt;
      active_r   <= active_nxt;
      special_r  <= special_nxt;
      seen_r     <= seen_r | loaded;
      sec_r      <= secured;
      ack_en_r   <= ack_en_nxt;
      tmo_flag_r <= tmo_flag_nxt;
      {awh_r, awa_r, wh_r, wd_r, ws_r, bv_r, br_r} <=
        {awh_nxt, awa_nxt, wh_nxt, wd_nxt, ws_nxt, bv_nxt, br_nxt};
      {arr_r, rv_r, rd_r, rr_r} <= {arr_nxt, rv_nxt, rd_nxt, rr_nxt};
    end
  end

  // Outputs from flops; HOST_READY_O, TB_REQ_O and MEM_REQ_O through gating logic
  assign AXI_AWREADY_O    = !awh_r;
  assign AXI_WREADY_O     = !wh_r;
  assign AXI_BVALID_O     = bv_r;
  assign AXI_BRESP_O      = br_r;
  assign AXI_ARREADY_O    = arr_r;
  assign AXI_RVALID_O     = rv_r;
  assign AXI_RDATA_O      = rd_r;
  assign AXI_RRESP_O      = rr_r;
  assign HOST_READY_O     = seen_r && state_r == sdta_pkg::ST_IDLE;
  assign RSP_VALID_O      = ser_rsp.valid;
  assign RSP_BYTE_O       = ser_rsp.data;
  assign RSP_ACK_O        = ack_r;
  assign MASS_ERASE_O     = erase_r;
  assign FLASH_RESTRICT_O = sec_r;
  assign SECURED_O        = sec_r;
  assign DEBUG_ACTIVE_O   = active_r;
  assign TB_REQ_O         = req_r && op_r == sdta_pkg::OP_TB;
  assign TB_HI_O          = hi_r;
  assign MEM_REQ_O        = req_r && op_r != sdta_pkg::OP_TB;
  assign MEM_ADDR_O       = addr_r;

  // Checks
  a_open_pattern: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    flash_security_reg[1:0] == `SDTA_SEC_OPEN |=> !SECURED_O) else $error("open pattern left secured");
  a_ns_closed: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    state_r == sdta_pkg::ST_IDLE && loaded && secured && !special_r
    |=> state_r == sdta_pkg::ST_IDLE && !MASS_ERASE_O) else $error("closed port took command");
  a_ss_active: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !seen_r && loaded && SPECIAL_MODE_I |=> DEBUG_ACTIVE_O) else $error("no active debug");
  a_mem_blocked: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    $rose(MEM_REQ_O) |-> !$past(secured)) else $error("secured memory access");
  a_restrict: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    FLASH_RESTRICT_O == $past(secured)) else $error("restrict not following security");
  a_ack_lead: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    RSP_ACK_O |-> !RSP_VALID_O ##1 RSP_VALID_O[*1]) else $error("data not after ack");
  a_tb_halves: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    TB_REQ_O && !$past(TB_REQ_O) && $past(state_r) == sdta_pkg::ST_IDLE |-> !TB_HI_O)
    else $error("trace high half first");
  a_tmo_abort: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    state_r == sdta_pkg::ST_FETCH && req_r && tmo_r == `SDTA_TMO_CYC && !TB_RDY_I && !MEM_ACK_I
    |=> state_r == sdta_pkg::ST_IDLE && tmo_flag_r) else $error("timeout not taken");
  a_ws_status: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    state_r == sdta_pkg::ST_ACK && op_r == sdta_pkg::OP_MEM_WS |=> ##1 RSP_BYTE_O == $past(status, 2))
    else $error("status byte not first");
  a_refused: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    state_r == sdta_pkg::ST_IDLE && HOST_VALID_I && enabled && !allowed
    |=> state_r == sdta_pkg::ST_IDLE && !req_r && HOST_READY_O) else $error("refused not idle");
  c_trace_read: cover property (@(posedge CLK_I) TB_REQ_O && TB_HI_O && TB_RDY_I);
  c_mem_ws: cover property (@(posedge CLK_I) state_r == sdta_pkg::ST_ACK && op_r == sdta_pkg::OP_MEM_WS);
  c_erase_sec: cover property (@(posedge CLK_I) MASS_ERASE_O && SECURED_O);
endmodule // sdta_top

`default_nettype wire

// ==== sdta_far_model.sv ====
/*
  Trace buffer and memory responder on the far side of the debug block.
  Assumes each request is held until it is answered.
*/
`timescale 1ns/10ps
`default_nettype none

module sdta_far_model #(
  parameter logic [63:0] LINE = 64'h0123_4567_89AB_CDEF
) (
  // Clock, delay and requests
  input  wire logic       clk_i,
  input  wire logic [3:0] dly_i,
  input  wire logic       tb_req_i,
  input  wire logic       tb_hi_i,
  input  wire logic       mem_req_i,
  // Answers
  output logic            tb_rdy_o,
  output logic     [31:0] tb_data_o,
  output logic            mem_ack_o,
  output logic     [7:0]  mem_data_o
);
  logic [3:0] cnt_r;
  logic       hit;

  // No second answer while the first is still being seen
  assign hit = (tb_req_i | mem_req_i) && cnt_r == dly_i && !tb_rdy_o && !mem_ack_o;

  initial begin
    {cnt_r, tb_rdy_o, tb_data_o, mem_ack_o, mem_data_o} = '0;
  end

  // Answer after dly_i cycles; idle data toggles so stale data never matches
  always @(posedge clk_i) begin
    cnt_r <= ((tb_req_i | mem_req_i) && !hit) ? cnt_r + 4'h1 : 4'h0;
    tb_rdy_o <= hit && tb_req_i;
    mem_ack_o <= hit && mem_req_i;
    tb_data_o <= hit ? (tb_hi_i ? LINE[63:32] : LINE[31:0]) : ~tb_data_o;
    mem_data_o <= hit ? LINE[7:0] : ~mem_data_o;
  end
endmodule // sdta_far_model

`default_nettype wire

// ==== sdta_top_test.sv ====
/*
  Self-checking bench for the secure debug trace access block.
  Assumes the far-side model answers trace requests.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sdta_map.svh"

module sdta_top_test;
  localparam logic [63:0] LINE = 64'h0123_4567_89AB_CDEF;
  logic CLK_I, SYS_RST_I, AXI_AWVALID_I, AXI_WVALID_I, AXI_BREADY_I, AXI_ARVALID_I;
  logic AXI_RREADY_I, AXI_AWREADY_O, AXI_WREADY_O, AXI_BVALID_O, AXI_ARREADY_O, AXI_RVALID_O;
  logic HOST_VALID_I, HOST_READY_O, RSP_VALID_O, RSP_ACK_O, SPECIAL_MODE_I, BACKDOOR_OK_I;
  logic SEC_PROG_WE_I, ERASE_DONE_I, MASS_ERASE_O, FLASH_RESTRICT_O, SECURED_O, DEBUG_ACTIVE_O;
  logic TB_REQ_O, TB_HI_O, TB_RDY_I, MEM_REQ_O, MEM_ACK_I;
  logic [7:0]  AXI_AWADDR_I, AXI_ARADDR_I, HOST_BYTE_I, NV_SEC_BYTE_I, SEC_PROG_BYTE_I;
  logic [7:0]  RSP_BYTE_O, MEM_RDATA_I;
  logic [31:0] AXI_WDATA_I, AXI_RDATA_O, TB_DATA_I, rd;
  logic [23:0] MEM_ADDR_O;
  logic [3:0]  AXI_WSTRB_I, dly;
  logic [1:0]  AXI_BRESP_O, AXI_RRESP_O, rr;
  logic [63:0] got;
  int          err_count, samples_checked, acks, n;

  sdta_top u_dut (.CLK_I, .SYS_RST_I, .AXI_AWVALID_I, .AXI_AWADDR_I, .AXI_AWREADY_O,
    .AXI_WVALID_I, .AXI_WDATA_I, .AXI_WSTRB_I, .AXI_WREADY_O, .AXI_BVALID_O, .AXI_BRESP_O,
    .AXI_BREADY_I, .AXI_ARVALID_I, .AXI_ARADDR_I, .AXI_ARREADY_O, .AXI_RVALID_O, .AXI_RDATA_O,
    .AXI_RRESP_O, .AXI_RREADY_I, .HOST_VALID_I, .HOST_BYTE_I, .HOST_READY_O, .RSP_VALID_O,
    .RSP_BYTE_O, .RSP_ACK_O, .SPECIAL_MODE_I, .NV_SEC_BYTE_I, .BACKDOOR_OK_I, .SEC_PROG_WE_I,
    .SEC_PROG_BYTE_I, .ERASE_DONE_I, .MASS_ERASE_O, .FLASH_RESTRICT_O, .SECURED_O,
    .DEBUG_ACTIVE_O, .TB_REQ_O, .TB_HI_O, .TB_RDY_I, .TB_DATA_I, .MEM_REQ_O, .MEM_ADDR_O,
    .MEM_ACK_I, .MEM_RDATA_I);
  sdta_far_model #(.LINE(LINE)) u_far (.clk_i(CLK_I), .dly_i(dly), .tb_req_i(TB_REQ_O),
    .tb_hi_i(TB_HI_O), .mem_req_i(MEM_REQ_O), .tb_rdy_o(TB_RDY_I), .tb_data_o(TB_DATA_I),
    .mem_ack_o(MEM_ACK_I), .mem_data_o(MEM_RDATA_I));

  // 100 MHz clock
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  task results;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task bad(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) bad("value differs");
  endtask
  // Every wait shares one bound so a hang always reaches the report
  task step;
    @(posedge CLK_I);
    n++;
    if (n > 400) begin
      bad("wait timed out");
      results;
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    {AXI_AWADDR_I, AXI_WDATA_I} <= {a, d};
    {AXI_AWVALID_I, AXI_WVALID_I, AXI_BREADY_I} <= 3'h7;
    n = 0;
    do begin
      step;
      if (AXI_AWREADY_O === 1'b1) AXI_AWVALID_I <= 1'b0;
      if (AXI_WREADY_O === 1'b1) AXI_WVALID_I <= 1'b0;
    end while (AXI_BVALID_O !== 1'b1);
    r = AXI_BRESP_O;
    AXI_BREADY_I <= 1'b0;
    @(posedge CLK_I);
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    {AXI_ARADDR_I, AXI_ARVALID_I, AXI_RREADY_I} <= {a, 2'h3};
    n = 0;
    do begin
      step;
      if (AXI_ARREADY_O === 1'b1) AXI_ARVALID_I <= 1'b0;
    end while (AXI_RVALID_O !== 1'b1);
    {d, r} = {AXI_RDATA_O, AXI_RRESP_O};
    AXI_RREADY_I <= 1'b0;
    @(posedge CLK_I);
  endtask
  task hsend(input logic [7:0] b);
    n = 0;
    do step; while (HOST_READY_O !== 1'b1);
    {HOST_VALID_I, HOST_BYTE_I} <= {1'b1, b};
    @(posedge CLK_I);
    HOST_VALID_I <= 1'b0;
  endtask
  // Argument byte; a gap before it is allowed while the command waits
  task harg(input logic [7:0] b);
    @(posedge CLK_I);
    {HOST_VALID_I, HOST_BYTE_I} <= {1'b1, b};
    @(posedge CLK_I);
    HOST_VALID_I <= 1'b0;
  endtask
  task rx(input int nb);
    int k;
    {got, acks, n, k} = '0;
    while (k < nb) begin
      step;
      if (RSP_ACK_O === 1'b1) acks++;
      if (RSP_VALID_O === 1'b1) begin
        got = {got[55:0], RSP_BYTE_O};
        k++;
      end
    end
  endtask
  task quiet(input int c);
    repeat (c) begin
      @(posedge CLK_I);
      chk({62'h0, RSP_VALID_O, TB_REQ_O | MEM_REQ_O}, 64'h0);
    end
  endtask
  task rst(input logic [7:0] nv, input logic sp);
    {SYS_RST_I, NV_SEC_BYTE_I, SPECIAL_MODE_I} <= {1'b1, nv, sp};
    repeat (8) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    repeat (4) @(posedge CLK_I);
  endtask

  // Main sequence
  initial begin
    {AXI_AWVALID_I, AXI_WVALID_I, AXI_BREADY_I, AXI_ARVALID_I, AXI_RREADY_I} = '0;
    {AXI_AWADDR_I, AXI_ARADDR_I, AXI_WDATA_I, HOST_VALID_I, HOST_BYTE_I} = '0;
    {BACKDOOR_OK_I, SEC_PROG_WE_I, SEC_PROG_BYTE_I, ERASE_DONE_I, dly} = '0;
    {SYS_RST_I, SPECIAL_MODE_I, NV_SEC_BYTE_I, AXI_WSTRB_I} = {10'h200, 4'hF};
    {err_count, samples_checked} = '0;
    for (int p = 0; p < 4; p++) begin
      rst(8'hA4 | p[7:0], 1'b1);
      chk(SECURED_O, p != 2);
      chk(DEBUG_ACTIVE_O, 1'b1);
      axi_rd(`SDTA_OFS_FLASH_SECURITY_REG, rd, rr);
      chk(rd, {24'h0, 8'hA4 | p[7:0]});
    end
    $display("security decode test done");
    rst(8'h01, 1'b1);
    hsend(`SDTA_OP_READ_TB);
    quiet(40);
    chk({HOST_READY_O, FLASH_RESTRICT_O}, 2'h3);
    hsend(`SDTA_OP_ERASE);
    n = 0;
    do step; while (MASS_ERASE_O !== 1'b1);
    chk(MASS_ERASE_O, 1'b1);
    ERASE_DONE_I <= 1'b1;
    @(posedge CLK_I);
    ERASE_DONE_I <= 1'b0;
    repeat (3) @(posedge CLK_I);
    chk(SECURED_O, 1'b0);
    $display("secured special test done");
    rst(8'h03, 1'b0);
    hsend(`SDTA_OP_CSR_RD);
    quiet(20);
    $display("secured normal test done");
    rst(8'h02, 1'b1);
    axi_wr(`SDTA_OFS_CTRL, 32'h0000_0001, rr);
    chk(rr, `SDTA_RESP_OKAY);
    // Prompt, then slow, far side
    for (int d = 0; d < 2; d++) begin
      dly <= (d == 0) ? 4'h0 : 4'h6;
      hsend(`SDTA_OP_READ_TB);
      rx(8);
      chk(got, {LINE[31:0], LINE[63:32]});
      chk(acks, 2);
    end
    $display("trace read test done");
    // Plain read with acknowledge, then the status variant
    for (int w = 0; w < 2; w++) begin
      hsend(w ? `SDTA_OP_MEM_RD_WS : `SDTA_OP_MEM_RD);
      harg(8'h12);
      harg(8'h34);
      harg(8'h56);
      rx(1 + w);
      chk(MEM_ADDR_O, 24'h12_3456);
      chk(got, w ? {8'h6D, LINE[7:0]} : {8'h00, LINE[7:0]});
      chk(acks, 1 - w);
    end
    $display("memory read test done");
    axi_wr(`SDTA_OFS_CTRL, 32'h0000_0000, rr);
    hsend(`SDTA_OP_READ_TB);
    rx(8);
    chk(got, {LINE[31:0], LINE[63:32]});
    chk(acks, 0);
    // Host without acknowledge keeps the fixed pause before reading on
    repeat (`SDTA_DLY_CYC) @(posedge CLK_I);
    $display("no acknowledge test done");
    axi_rd(8'h0C, rd, rr);
    chk({rd, rr}, {32'h0, `SDTA_RESP_SLVERR});
    axi_wr(`SDTA_OFS_STATUS, 32'h0000_0000, rr);
    chk(rr, `SDTA_RESP_SLVERR);
    axi_rd(`SDTA_OFS_CTRL, rd, rr);
    chk({rd, rr}, {32'h0, `SDTA_RESP_OKAY});
    $display("register bus test done");
    results;
  end
endmodule // sdta_top_test

`default_nettype wire
